// file: hdl/imudi_pkg.sv
package imudi_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned SAMPLE_RATE_SPS = 2000;
	// whole clock cycles between two pre-decimation samples
	localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_RATE_SPS;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int unsigned SAMPLE_W = 16;
	localparam int unsigned RESULT_W = 32;
	localparam int unsigned HALF_W = 16;
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DEC_W = 11;
	localparam int unsigned NUM_CH = 4;

	// ----------------------------------------------------------------
	// channel order inside the integrator bank
	// ----------------------------------------------------------------
	localparam int unsigned CH_PITCH = 0;
	localparam int unsigned CH_YAW = 1;
	localparam int unsigned CH_VEL_FIRST = 2;
	localparam int unsigned CH_VEL_SECOND = 3;

	// ----------------------------------------------------------------
	// byte addresses of the result words
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] PITCH_ANGLE_STEP_LOW = 7'h28;
	localparam logic [ADDR_W-1:0] PITCH_ANGLE_STEP_HIGH = 7'h2a;
	localparam logic [ADDR_W-1:0] YAW_ANGLE_STEP_LOW = 7'h2c;
	localparam logic [ADDR_W-1:0] YAW_ANGLE_STEP_HIGH = 7'h2e;
	localparam logic [ADDR_W-1:0] FIRST_AXIS_SPEED_STEP_LOW = 7'h30;
	localparam logic [ADDR_W-1:0] FIRST_AXIS_SPEED_STEP_HIGH = 7'h32;
	localparam logic [ADDR_W-1:0] SECOND_AXIS_SPEED_STEP_LOW = 7'h34;
	localparam logic [ADDR_W-1:0] SECOND_AXIS_SPEED_STEP_HIGH = 7'h36;
	// read data for any address outside the map
	localparam logic [HALF_W-1:0] UNMAPPED_DATA = 16'h0000;
	localparam logic [RESULT_W-1:0] RESULT_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic signed [SAMPLE_W-1:0] gyro_pitch;
		logic signed [SAMPLE_W-1:0] gyro_yaw;
		logic signed [SAMPLE_W-1:0] accel_first;
		logic signed [SAMPLE_W-1:0] accel_second;
	} imudi_samples_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
	} imudi_rd_req_s;

endpackage : imudi_pkg

// file: hdl/imudi_tick.sv
`timescale 1ns/100ps
module imudi_tick #(
	parameter int unsigned DIV = imudi_pkg::SAMPLE_DIV
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// sample strobe
	output logic tick_o
);

	localparam int unsigned CNT_W = $clog2(DIV + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

	logic [CNT_W-1:0] cnt_q;

	// free running divider, wraps after DIV cycles
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cnt_q <= '0;
		else if (cnt_q == LAST)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 1'b1;
	end

	assign tick_o = (cnt_q == LAST);

	// ----------------------------------------------------------------
	// strobe spacing check
	// ----------------------------------------------------------------
	localparam int unsigned GAP_W = $clog2(DIV + 1) + 1;

	logic [GAP_W-1:0] gap_q;
	logic seen_tick_q;

	// cycles since the last strobe, counted apart from the divider itself
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			gap_q <= '0;
			seen_tick_q <= 1'b0;
		end
		else
		begin
			gap_q <= tick_o ? GAP_W'(1) : gap_q + 1'b1;
			seen_tick_q <= seen_tick_q | tick_o;
		end
	end

	property p_tick_spacing;
		@(posedge clock_i) disable iff (!rst_n_i)
		tick_o && seen_tick_q |-> gap_q == GAP_W'(DIV);
	endproperty
	a_tick_spacing: assert property (p_tick_spacing)
		else $error("sample strobe spacing wrong");

endmodule : imudi_tick

// file: hdl/imudi_trap_integ.sv
`timescale 1ns/100ps
module imudi_trap_integ #(
	parameter int unsigned IN_W = imudi_pkg::SAMPLE_W,
	parameter int unsigned OUT_W = imudi_pkg::RESULT_W
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// sample stream
	input wire logic tick_i,
	input wire logic last_i,
	input wire logic signed [IN_W-1:0] sample_i,
	// window result
	output logic signed [OUT_W-1:0] result_o
);

	logic signed [IN_W-1:0] prev_q;
	logic signed [OUT_W-1:0] acc_q;
	logic signed [OUT_W-1:0] step;

	// current plus previous sample, sign extended
	assign step = OUT_W'(sample_i) + OUT_W'(prev_q);

	// previous sample carries across window borders
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			prev_q <= '0;
		else if (tick_i)
			prev_q <= sample_i;
	end

	// restart per update
	// running sum, restarted at each window end
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			acc_q <= '0;
		else if (tick_i && last_i)
			acc_q <= '0;
		else if (tick_i)
			acc_q <= acc_q + step;
	end

	// both halves load in one edge; a reader taking the two halves in different cycles can still see a mix across an update
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			result_o <= OUT_W'(imudi_pkg::RESULT_RESET);
		else if (tick_i && last_i)
			result_o <= acc_q + step;
	end

endmodule : imudi_trap_integ

// file: hdl/imudi_top.sv
`timescale 1ns/100ps
module imudi_top #(
	parameter int unsigned SAMPLE_DIV = imudi_pkg::SAMPLE_DIV,
	parameter int unsigned DEC_W = imudi_pkg::DEC_W
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// filtered sensor samples, same clock domain
	input wire imudi_pkg::imudi_samples_s samples_i,
	// decimation control
	input wire logic [DEC_W-1:0] output_decimation_setting_i,
	// register read port
	input wire imudi_pkg::imudi_rd_req_s rd_req_i,
	output logic [imudi_pkg::HALF_W-1:0] rd_data_o,
	// update indication
	output logic sample_tick_o,
	output logic data_update_o
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	localparam int unsigned NCH = imudi_pkg::NUM_CH;
	localparam int unsigned SW = imudi_pkg::SAMPLE_W;
	localparam int unsigned RW = imudi_pkg::RESULT_W;
	localparam int unsigned HW = imudi_pkg::HALF_W;

	logic tick;
	logic last;
	logic [DEC_W-1:0] win_q;
	logic update_q;
	logic [HW-1:0] rd_data_q;
	logic signed [SW-1:0] chan [NCH];
	logic signed [RW-1:0] result [NCH];

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// pick one 16-bit half of a 32-bit result
	function automatic logic [HW-1:0] half_of(input logic [RW-1:0] value, input logic upper);
		half_of = upper ? value[RW-1:HW] : value[HW-1:0];
	endfunction : half_of

	// ----------------------------------------------------------------
	// sample strobe
	// ----------------------------------------------------------------
	// internal sample rate
	imudi_tick #(
		.DIV(SAMPLE_DIV)
	) u_tick (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.tick_o(tick)
	);

	// ----------------------------------------------------------------
	// decimation window
	// ----------------------------------------------------------------
	// window of setting plus one
	// a setting lowered mid-window to the strobe count or below ends the window at the next strobe
	assign last = (win_q >= output_decimation_setting_i);

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			win_q <= '0;
		else if (tick && last)
			win_q <= '0;
		else if (tick)
			win_q <= win_q + 1'b1;
	end

	// update marker lines up with the new results
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			update_q <= 1'b0;
		else
			update_q <= tick && last;
	end

	// ----------------------------------------------------------------
	// integrator bank
	// ----------------------------------------------------------------
	assign chan[imudi_pkg::CH_PITCH] = samples_i.gyro_pitch;
	assign chan[imudi_pkg::CH_YAW] = samples_i.gyro_yaw;
	assign chan[imudi_pkg::CH_VEL_FIRST] = samples_i.accel_first;
	assign chan[imudi_pkg::CH_VEL_SECOND] = samples_i.accel_second;

	for (genvar g = 0; g < NCH; g++)
	begin : g_integ
		imudi_trap_integ #(
			.IN_W(SW),
			.OUT_W(RW)
		) u_integ (
			.clock_i(clock_i),
			.rst_n_i(rst_n_i),
			.tick_i(tick),
			.last_i(last),
			.sample_i(chan[g]),
			.result_o(result[g])
		);
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	// word pairs form results
	// both bytes of a word address the same 16-bit register
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rd_data_q <= imudi_pkg::UNMAPPED_DATA;
		else
		begin
			unique case ({rd_req_i.addr[imudi_pkg::ADDR_W-1:1], 1'b0})
				imudi_pkg::PITCH_ANGLE_STEP_LOW:
					rd_data_q <= half_of(result[imudi_pkg::CH_PITCH], 1'b0);
				imudi_pkg::PITCH_ANGLE_STEP_HIGH:
					rd_data_q <= half_of(result[imudi_pkg::CH_PITCH], 1'b1);
				imudi_pkg::YAW_ANGLE_STEP_LOW:
					rd_data_q <= half_of(result[imudi_pkg::CH_YAW], 1'b0);
				imudi_pkg::YAW_ANGLE_STEP_HIGH:
					rd_data_q <= half_of(result[imudi_pkg::CH_YAW], 1'b1);
				imudi_pkg::FIRST_AXIS_SPEED_STEP_LOW:
					rd_data_q <= half_of(result[imudi_pkg::CH_VEL_FIRST], 1'b0);
				imudi_pkg::FIRST_AXIS_SPEED_STEP_HIGH:
					rd_data_q <= half_of(result[imudi_pkg::CH_VEL_FIRST], 1'b1);
				imudi_pkg::SECOND_AXIS_SPEED_STEP_LOW:
					rd_data_q <= half_of(result[imudi_pkg::CH_VEL_SECOND], 1'b0);
				imudi_pkg::SECOND_AXIS_SPEED_STEP_HIGH:
					rd_data_q <= half_of(result[imudi_pkg::CH_VEL_SECOND], 1'b1);
				default:
					rd_data_q <= imudi_pkg::UNMAPPED_DATA;
			endcase
		end
	end

	assign rd_data_o = rd_data_q;
	assign sample_tick_o = tick;
	assign data_update_o = update_q;

	// ----------------------------------------------------------------
	// checking helpers
	// ----------------------------------------------------------------
	logic [DEC_W:0] nticks_q;
	logic seen_upd_q;
	logic [DEC_W-1:0] dec_prev_q;
	logic dec_steady_q;
	logic signed [RW-1:0] ref_sum_q [NCH];
	logic signed [SW-1:0] ref_p0_q [NCH];
	logic signed [SW-1:0] ref_prev_q [NCH];
	logic signed [RW-1:0] ref_res_q [NCH];

	// strobes within the current window, and setting stability
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			nticks_q <= '0;
			seen_upd_q <= 1'b0;
			dec_prev_q <= '0;
			dec_steady_q <= 1'b0;
		end
		else
		begin
			if (tick && last)
				nticks_q <= '0;
			else if (tick)
				nticks_q <= nticks_q + 1'b1;
			seen_upd_q <= seen_upd_q | update_q;
			dec_prev_q <= output_decimation_setting_i;
			if (update_q)
				dec_steady_q <= 1'b1;
			else if (dec_prev_q != output_decimation_setting_i)
				dec_steady_q <= 1'b0;
		end
	end

	// reference in closed form: twice the sample sum, minus the last
	// sample, plus the one just before the window
	for (genvar r = 0; r < NCH; r++)
	begin : g_ref
		always_ff @(posedge clock_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
			begin
				ref_sum_q[r] <= '0;
				ref_p0_q[r] <= '0;
				ref_prev_q[r] <= '0;
				ref_res_q[r] <= '0;
			end
			else if (tick)
			begin
				ref_prev_q[r] <= chan[r];
				if (win_q == '0)
					ref_p0_q[r] <= ref_prev_q[r];
				if (last)
				begin
					ref_sum_q[r] <= '0;
					ref_res_q[r] <= RW'(2) * (ref_sum_q[r] + RW'(chan[r])) - RW'(chan[r])
						+ RW'((win_q == '0) ? ref_prev_q[r] : ref_p0_q[r]);
				end
				else
					ref_sum_q[r] <= ref_sum_q[r] + RW'(chan[r]);
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	property p_window_len;
		update_q && seen_upd_q && dec_steady_q
			|-> $past(nticks_q) == (DEC_W + 1)'($past(output_decimation_setting_i));
	endproperty
	a_window_len: assert property (p_window_len)
		else $error("window length not setting plus one");

	property p_vel_sum;
		update_q && seen_upd_q |-> result[imudi_pkg::CH_VEL_FIRST]
			== ref_res_q[imudi_pkg::CH_VEL_FIRST];
	endproperty
	a_vel_sum: assert property (p_vel_sum)
		else $error("speed result differs from trapezoid sum");

	property p_ang_sum;
		update_q && seen_upd_q |-> result[imudi_pkg::CH_YAW] == ref_res_q[imudi_pkg::CH_YAW];
	endproperty
	a_ang_sum: assert property (p_ang_sum)
		else $error("angle result differs from trapezoid sum");

	property p_restart;
		update_q |-> win_q == '0 ##1 !update_q;
	endproperty
	a_restart: assert property (p_restart)
		else $error("window did not restart at update");

	property p_coherent;
		!update_q |-> $stable(result[0]) && $stable(result[1])
			&& $stable(result[2]) && $stable(result[3]);
	endproperty
	a_coherent: assert property (p_coherent)
		else $error("result changed outside an update");

	property p_pitch_hi;
		rd_req_i.addr == imudi_pkg::PITCH_ANGLE_STEP_HIGH
			|=> rd_data_o == $past(result[imudi_pkg::CH_PITCH][RW-1:HW]);
	endproperty
	a_pitch_hi: assert property (p_pitch_hi)
		else $error("pitch high word wrong");

	property p_pitch_lo;
		rd_req_i.addr == imudi_pkg::PITCH_ANGLE_STEP_LOW + 1'b1
			|=> rd_data_o == $past(result[imudi_pkg::CH_PITCH][HW-1:0]);
	endproperty
	a_pitch_lo: assert property (p_pitch_lo)
		else $error("pitch low word wrong");

	property p_yaw_hi;
		rd_req_i.addr == imudi_pkg::YAW_ANGLE_STEP_HIGH
			|=> rd_data_o == $past(result[imudi_pkg::CH_YAW][RW-1:HW]);
	endproperty
	a_yaw_hi: assert property (p_yaw_hi)
		else $error("yaw high word wrong");

	property p_vel_first_hi;
		rd_req_i.addr == imudi_pkg::FIRST_AXIS_SPEED_STEP_HIGH
			|=> rd_data_o == $past(result[imudi_pkg::CH_VEL_FIRST][RW-1:HW]);
	endproperty
	a_vel_first_hi: assert property (p_vel_first_hi)
		else $error("first speed high word wrong");

	property p_vel_second_lo;
		rd_req_i.addr == imudi_pkg::SECOND_AXIS_SPEED_STEP_LOW
			|=> rd_data_o == $past(result[imudi_pkg::CH_VEL_SECOND][HW-1:0]);
	endproperty
	a_vel_second_lo: assert property (p_vel_second_lo)
		else $error("second speed low word wrong");

	property p_unmapped;
		rd_req_i.addr < imudi_pkg::PITCH_ANGLE_STEP_LOW |=> rd_data_o == imudi_pkg::UNMAPPED_DATA;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	// ----------------------------------------------------------------
	// coverage
	// ----------------------------------------------------------------
	c_single_sample: cover property (update_q && output_decimation_setting_i == '0);
	c_long_window: cover property (update_q && output_decimation_setting_i > DEC_W'(2));
	c_negative: cover property (update_q && result[imudi_pkg::CH_PITCH] < 0);
	c_read_after_update: cover property (update_q ##1
		rd_req_i.addr == imudi_pkg::SECOND_AXIS_SPEED_STEP_HIGH);

endmodule : imudi_top

// file: test/imudi_host_model.sv
`timescale 1ns/100ps
module imudi_host_model (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// request from the bench
	input wire logic go_i,
	input wire logic [imudi_pkg::ADDR_W-1:0] base_i,
	output logic [imudi_pkg::RESULT_W-1:0] value_o,
	output logic done_o,
	// register read port
	output imudi_pkg::imudi_rd_req_s rd_req_o,
	input wire logic [imudi_pkg::HALF_W-1:0] rd_data_i
);
	logic [2:0] step_q;

	// ----------------------------------------------------------------
	// word pair reader
	// ----------------------------------------------------------------
	// upper then lower
	// idle parks on an unmapped address so stale data is never reused
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			step_q <= 3'h0;
			done_o <= 1'b0;
			value_o <= 32'h0000_0000;
			rd_req_o.addr <= 7'h7e;
		end
		else
		begin
			case (step_q)
				3'h0:
				begin
					done_o <= done_o & go_i;
					if (go_i && !done_o)
					begin
						rd_req_o.addr <= base_i + 7'h02;
						step_q <= 3'h1;
					end
				end
				3'h1:
				begin
					rd_req_o.addr <= base_i;
					step_q <= 3'h2;
				end
				3'h2:
				begin
					value_o[31:16] <= rd_data_i;
					rd_req_o.addr <= 7'h7e;
					step_q <= 3'h3;
				end
				default:
				begin
					value_o[15:0] <= rd_data_i;
					done_o <= 1'b1;
					step_q <= 3'h0;
				end
			endcase
		end
	end
endmodule : imudi_host_model

// file: test/imudi_top_bench.sv
`timescale 1ns/100ps
module imudi_top_bench;
	localparam int SDIV = 20;
	logic clock_i;
	logic rst_n_i;
	imudi_pkg::imudi_samples_s samples_i;
	logic [10:0] setting;
	imudi_pkg::imudi_rd_req_s rd_req;
	logic [15:0] rd_data;
	logic sample_tick_o;
	logic data_update_o;
	logic go;
	logic [6:0] base;
	logic [31:0] host_value;
	logic host_done;
	logic [31:0] seed;
	logic [15:0] corner_v;
	logic [31:0] exp_q [4];
	logic [31:0] acc [4];
	logic [15:0] prev [4];
	logic [15:0] s [4];
	int cnt;
	int gap;
	logic upd_pend;
	int n_errors;
	int total_checks;

	imudi_top #(.SAMPLE_DIV(SDIV), .DEC_W(11)) dut (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.samples_i(samples_i),
		.output_decimation_setting_i(setting),
		.rd_req_i(rd_req),
		.rd_data_o(rd_data),
		.sample_tick_o(sample_tick_o),
		.data_update_o(data_update_o)
	);

	imudi_host_model host (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.go_i(go),
		.base_i(base),
		.value_o(host_value),
		.done_o(host_done),
		.rd_req_o(rd_req),
		.rd_data_i(rd_data)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// one trapezoid step, wrapping in 32 bits
	function automatic logic [31:0] trap_step(input logic [31:0] a, input logic [15:0] x,
		input logic [15:0] y);
		return a + {{16{x[15]}}, x} + {{16{y[15]}}, y};
	endfunction : trap_step

	task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
		total_checks++;
		if (got !== want)
		begin
			n_errors++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	task automatic host_read(input logic [6:0] b, output logic [31:0] v);
		int i;
		base <= b;
		go <= 1'b1;
		// let the model take go first: done of the previous read is still
		// high in this step and would end this read at once
		@(posedge clock_i);
		for (i = 0; i < 20 && host_done !== 1'b1; i++)
			@(posedge clock_i);
		if (host_done !== 1'b1)
		begin
			check(0, 1, "read hang");
			test_done();
		end
		v = host_value;
		go <= 1'b0;
		@(posedge clock_i);
	endtask : host_read

	task automatic wait_update();
		int i;
		for (i = 0; i < 3000; i++)
		begin
			@(posedge clock_i);
			if (data_update_o === 1'b1)
				break;
		end
		if (i == 3000)
		begin
			check(0, 1, "no update");
			test_done();
		end
	endtask : wait_update

	task automatic read_axis(input int ch, input logic odd, input logic [31:0] want);
		logic [31:0] v;
		host_read(7'h28 + 7'(4 * ch) + {6'h00, odd}, v);
		check(v, want, "axis result");
	endtask : read_axis

	// ----------------------------------------------------------------
	// clock and stimulus
	// ----------------------------------------------------------------
	always #10 clock_i = ~clock_i;

	// fresh random samples every cycle except in the full-scale runs, so values between strobes must be ignored
	always @(posedge clock_i)
	begin
		if (corner_v != 16'h0000)
			samples_i <= {4{corner_v}};
		else
			samples_i <= {rnd(), rnd()};
	end

	// ----------------------------------------------------------------
	// reference integrator
	// ----------------------------------------------------------------
	// window model
	always @(posedge clock_i or negedge rst_n_i)
	begin
		s[0] = samples_i.gyro_pitch;
		s[1] = samples_i.gyro_yaw;
		s[2] = samples_i.accel_first;
		s[3] = samples_i.accel_second;
		if (!rst_n_i)
		begin
			for (int c = 0; c < 4; c++)
			begin
				exp_q[c] = 32'h0000_0000;
				acc[c] = 32'h0000_0000;
				prev[c] = 16'h0000;
			end
			cnt = 0;
			gap = 0;
			upd_pend = 1'b0;
		end
		else
		begin
			check(data_update_o, upd_pend, "update pulse");
			upd_pend = 1'b0;
			if (sample_tick_o === 1'b1)
			begin
				check(gap, SDIV - 1, "strobe spacing");
				gap = 0;
				for (int c = 0; c < 4; c++)
				begin
					acc[c] = trap_step(acc[c], s[c], prev[c]);
					prev[c] = s[c];
				end
				cnt++;
				if (cnt >= int'(setting) + 1)
				begin
					exp_q = acc;
					for (int c = 0; c < 4; c++)
						acc[c] = 32'h0000_0000;
					cnt = 0;
					upd_pend = 1'b1;
				end
			end
			else
				gap++;
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [10:0] set_tab [5];
		logic [31:0] v;
		int ax;
		set_tab = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h005};
		clock_i = 1'b0;
		rst_n_i = 1'b0;
		samples_i = '0;
		setting = 11'h000;
		go = 1'b0;
		base = 7'h28;
		seed = 32'd25760;
		corner_v = 16'h0000;
		n_errors = 0;
		total_checks = 0;
		ax = 0;
		repeat (12) @(posedge clock_i);
		rst_n_i <= 1'b1;
		// settings sweep, two with full-scale samples
		for (int t = 0; t < 8; t++)
		begin
			@(posedge clock_i);
			v = rnd();
			setting <= (t < 5) ? set_tab[t] : 11'(v % 6);
			corner_v <= (t == 1) ? 16'h7fff : (t == 2) ? 16'h8000 : 16'h0000;
			repeat (4)
			begin
				wait_update();
				v = rnd();
				read_axis(ax % 4, v[0], exp_q[ax % 4]);
				ax++;
			end
			$display("test %0d done", t);
		end
		// unmapped addresses read as zero
		host_read(7'h00, v);
		check(v, 32'h0000_0000, "unmapped low");
		host_read(7'h38, v);
		check(v, 32'h0000_0000, "unmapped past map");
		host_read(7'h7c, v);
		check(v, 32'h0000_0000, "unmapped top");
		$display("test unmapped done");
		// reset in mid-window clears results and history
		@(posedge clock_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		read_axis(2, 1'b0, 32'h0000_0000);
		wait_update();
		read_axis(3, 1'b1, exp_q[3]);
		$display("test reset done");
		test_done();
	end
endmodule : imudi_top_bench
